// ==== pswd_pkg.sv ====
// Constants, types and timing tables for the pin-select watchdog supervisor.
// Assumes a 20 MHz reference clock and a 1 us internal time base.
package pswd_pkg;

  // Clock and time base
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned TICK_PERIOD_NS = 1000;
  localparam int unsigned TICK_DIV_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // Width of the microsecond counters; 60 s fits with room to spare
  localparam int CNT_W = 27;

  // Times in microseconds; one tick is one microsecond
  localparam logic [CNT_W-1:0] T_OFF = 27'h0000000;
  localparam logic [CNT_W-1:0] T_30US = 27'h000001E;
  localparam logic [CNT_W-1:0] T_200US = 27'h00000C8;
  localparam logic [CNT_W-1:0] T_1MS = 27'h00003E8;
  localparam logic [CNT_W-1:0] T_3MS = 27'h0000BB8;
  localparam logic [CNT_W-1:0] T_10MS = 27'h0002710;
  localparam logic [CNT_W-1:0] T_30MS = 27'h0007530;
  localparam logic [CNT_W-1:0] T_100MS = 27'h00186A0;
  localparam logic [CNT_W-1:0] T_300MS = 27'h00493E0;
  localparam logic [CNT_W-1:0] T_1S = 27'h00F4240;
  localparam logic [CNT_W-1:0] T_3S = 27'h02DC6C0;
  localparam logic [CNT_W-1:0] T_10S = 27'h0989680;
  localparam logic [CNT_W-1:0] T_60S = 27'h3938700;

  // Settle time after power-up or select change, and fault pulse widths
  localparam logic [CNT_W-1:0] SETTLE_US = 27'h000012C;
  localparam logic [CNT_W-1:0] PULSE_OD_US = T_100MS;
  localparam logic [CNT_W-1:0] PULSE_PP_US = T_1MS;

  // Select code that turns the watchdog off on every variant
  localparam logic [2:0] SEL_DISABLED = 3'h3;

  // Per-variant tables, indexed by the select code
  localparam logic [CNT_W-1:0] V0_TWD [8] = '{T_1MS, T_10MS, T_30MS, T_OFF, T_100MS, T_1S, T_10S, T_60S};
  localparam logic [CNT_W-1:0] V1_TWD [8] = '{T_1MS, T_3MS, T_10MS, T_OFF, T_100MS, T_300MS, T_3S, T_60S};
  localparam logic [CNT_W-1:0] V1_DLY = T_60S;
  localparam logic [CNT_W-1:0] V2_TWD [8] = '{T_3MS, T_3S, T_1S, T_OFF, T_30US, T_1S, T_10S, T_10S};
  localparam logic [CNT_W-1:0] V2_DLY [8] = '{T_3MS, T_3S, T_60S, T_OFF, T_200US, T_OFF, T_OFF, T_60S};
  localparam logic [7:0] V2_FIRST_EDGE = 8'h60;

  // Register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_COUNT = 4'h8;
  localparam logic [3:0] REG_FAULTS = 4'hC;

  // Control register fields and reset value
  localparam int CTRL_SW_SEL_EN_BIT = 0;
  localparam int CTRL_SW_SEL_LSB = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Status register fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_FAULT_BIT = 3;
  localparam int STAT_STROBE_BIT = 4;
  localparam int STAT_PENDING_BIT = 5;
  localparam int STAT_SEL_LSB = 8;

  // Watchdog phases, Gray coded along settle, startup, watch, fault
  typedef enum logic [2:0] {
    PSWD_SETTLE = 3'h0,
    PSWD_STARTUP = 3'h1,
    PSWD_WATCH = 3'h3,
    PSWD_FAULT = 3'h2,
    PSWD_OFF = 3'h6
  } pswd_state_t;

  // Timing chosen by variant and select code
  typedef struct packed {
    logic [CNT_W-1:0] twd;
    logic [CNT_W-1:0] dly;
    logic first_edge;
    logic disabled;
  } pswd_timing_t;

  // Look up startup delay and timeout for a variant and select code
  function automatic pswd_timing_t timing_of(input int variant, input logic [2:0] sel);
    pswd_timing_t t;
    t.disabled = (sel == SEL_DISABLED);
    t.first_edge = 1'b0;
    case (variant)
      0: begin
        t.twd = V0_TWD[sel];
        t.dly = V0_TWD[sel];
      end
      1: begin
        t.twd = V1_TWD[sel];
        t.dly = V1_DLY;
      end
      default: begin
        t.twd = V2_TWD[sel];
        t.dly = V2_DLY[sel];
        t.first_edge = V2_FIRST_EDGE[sel];
      end
    endcase
    return t;
  endfunction

endpackage

// ==== pswd_tick.sv ====
// Divider that makes the one-microsecond time base of the watchdog.
// Assumes a single free-running clock and synchronous active-low reset.
`timescale 1ns/1ps
module pswd_tick #(
  parameter int unsigned DIV = pswd_pkg::TICK_DIV_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  output logic tick_out
);

  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic tick_d;
  logic tick_q;

  // Count down and pulse once per period
  always_comb begin
    tick_d = 1'b0;
    cnt_d = cnt_q - 16'h0001;
    if (cnt_q == 16'h0000) begin
      tick_d = 1'b1;
      cnt_d = 16'(DIV - 1);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_out = tick_q;

endmodule // pswd_tick

// ==== pswd_top.sv ====
// Pin-select watchdog supervisor with an Avalon-MM register slave.
// Assumes strobe and select pins are synchronous to ref_clk_in; one clock.
//
// Function
// - Either strobe edge clears the timeout counter
// - Fault assertion also clears the timeout counter
// - Strobe stuck for full timeout triggers fault
// - Fault held low one pulse width, released
// - Pulse width by variant, active low
// - Output stays high while strobe keeps toggling
// - Variant and select pins set delay, timeout
// - Startup restarts at reset and select change
// - No counting or fault during startup delay
// - After startup, count timeout and watch strobe
// - Startup delays span 200 us to 60 s
// - First-edge option waits for first strobe edge
// - Seven timeout selections, 30 us to 60 s
// - One select code disables the watchdog
// - Second variant startup fixed at 60 s
// - First variant startup equals the timeout
// - Ignore strobe in fault, settle time, and startup unless first-edge
`timescale 1ns/1ps
module pswd_top #(
  parameter int VARIANT = 0,
  parameter int unsigned TICK_DIV = pswd_pkg::TICK_DIV_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic strobe_input_in,
  input wire logic timing_select_bit0_in,
  input wire logic timing_select_bit1_in,
  input wire logic timing_select_bit2_in,
  output logic fault_pulse_out,
  output logic fault_pulse_oe_out,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out
);

  localparam int CW = pswd_pkg::CNT_W;
  localparam int TIMING_VARIANT = VARIANT / 2;
  localparam bit PUSH_PULL = (VARIANT % 2) == 1;
  // Pulse width follows the output stage of the variant
  localparam logic [CW-1:0] PULSE_US = PUSH_PULL ? pswd_pkg::PULSE_PP_US : pswd_pkg::PULSE_OD_US;

  // Time base, select and strobe decode
  logic tick;
  logic [2:0] sel_pins;
  logic [2:0] sel_eff;
  logic sel_changed;
  logic strobe_edge;
  pswd_pkg::pswd_timing_t timing;

  // Watchdog phase and the shared microsecond counter
  pswd_pkg::pswd_state_t state_q;
  pswd_pkg::pswd_state_t state_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic strobe_q;
  logic strobe_d;
  logic [2:0] sel_q;
  logic [2:0] sel_d;
  logic pending_q;
  logic pending_d;

  // Pin outputs, all straight from flops, and the fault count
  logic fault_n_q;
  logic fault_n_d;
  logic oe_q;
  logic oe_d;
  logic [31:0] faults_q;
  logic [31:0] faults_d;

  // Register slave state
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic wreq_q;
  logic wreq_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [31:0] status_word;

  // One more tick completes the period; shared by settle, startup, watch and fault
  function automatic logic reached(input logic [CW-1:0] cnt, input logic [CW-1:0] limit);
    return (cnt + CW'(1)) >= limit;
  endfunction

  // Counter plus one tick, kept at counter width
  function automatic logic [CW-1:0] step(input logic [CW-1:0] cnt);
    return cnt + CW'(1);
  endfunction

  // Microsecond time base
  pswd_tick #(
    .DIV(TICK_DIV)
  ) u_tick (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .tick_out(tick)
  );

  // Select source: pins, or the control register when software owns it
  assign sel_pins = {timing_select_bit2_in, timing_select_bit1_in, timing_select_bit0_in};
  assign sel_eff = ctrl_q[pswd_pkg::CTRL_SW_SEL_EN_BIT] ? ctrl_q[pswd_pkg::CTRL_SW_SEL_LSB +: 3] : sel_pins;
  assign sel_changed = (sel_eff != sel_q);
  // Either level change counts; pins are already synchronous
  assign strobe_edge = (strobe_input_in != strobe_q);
  // Timing from the registered code, so a pin glitch cannot split a period
  assign timing = pswd_pkg::timing_of(TIMING_VARIANT, sel_q);

  // Next phase and counter; one counter serves settle, startup, watch and pulse
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    pending_d = pending_q;
    faults_d = faults_q;
    sel_d = sel_eff;
    strobe_d = strobe_input_in;
    case (state_q)
      pswd_pkg::PSWD_SETTLE: begin
        // Strobe ignored here; a new code restarts the wait
        if (sel_changed) begin
          cnt_d = '0;
        end else if (tick) begin
          if (reached(cnt_q, pswd_pkg::SETTLE_US)) begin
            cnt_d = '0;
            if (timing.disabled) begin
              state_d = pswd_pkg::PSWD_OFF;
            end else begin
              state_d = pswd_pkg::PSWD_STARTUP;
            end
          end else begin
            cnt_d = step(cnt_q);
          end
        end
      end
      pswd_pkg::PSWD_STARTUP: begin
        // No timeout and no fault while the startup delay runs
        if (sel_changed) begin
          cnt_d = '0;
          state_d = pswd_pkg::PSWD_SETTLE;
        end else if (timing.first_edge) begin
          // No time limit: a processor that never strobes is never caught
          if (strobe_edge) begin
            cnt_d = '0;
            state_d = pswd_pkg::PSWD_WATCH;
          end
        end else if (tick) begin
          if (reached(cnt_q, timing.dly)) begin
            cnt_d = '0;
            state_d = pswd_pkg::PSWD_WATCH;
          end else begin
            cnt_d = step(cnt_q);
          end
        end
      end
      pswd_pkg::PSWD_WATCH: begin
        if (sel_changed) begin
          cnt_d = '0;
          state_d = pswd_pkg::PSWD_SETTLE;
        end else if (strobe_edge) begin
          cnt_d = '0;
        end else if (tick) begin
          if (reached(cnt_q, timing.twd)) begin
            // Entering the pulse clears the counter for the width count
            cnt_d = '0;
            state_d = pswd_pkg::PSWD_FAULT;
            faults_d = faults_q + 32'h00000001;
          end else begin
            cnt_d = step(cnt_q);
          end
        end
      end
      pswd_pkg::PSWD_FAULT: begin
        // Strobe ignored; a select change waits for the pulse to end
        if (sel_changed) begin
          pending_d = 1'b1;
        end
        if (tick) begin
          if (reached(cnt_q, PULSE_US)) begin
            cnt_d = '0;
            // A change seen in this very cycle still leads to settle
            pending_d = 1'b0;
            if (pending_q || sel_changed) begin
              state_d = pswd_pkg::PSWD_SETTLE;
            end else begin
              state_d = pswd_pkg::PSWD_WATCH;
            end
          end else begin
            cnt_d = step(cnt_q);
          end
        end
      end
      pswd_pkg::PSWD_OFF: begin
        // Counter parked; only a new select code wakes the block
        cnt_d = '0;
        if (sel_changed) begin
          state_d = pswd_pkg::PSWD_SETTLE;
        end
      end
      default: begin
        cnt_d = '0;
        state_d = pswd_pkg::PSWD_SETTLE;
      end
    endcase
  end

  // Pin levels follow the next phase so they move together with it
  always_comb begin
    fault_n_d = (state_d != pswd_pkg::PSWD_FAULT);
    // Open drain drives only while pulling low; push-pull always drives
    oe_d = PUSH_PULL ? 1'b1 : !fault_n_d;
  end

  // Watchdog registers
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      state_q <= pswd_pkg::PSWD_SETTLE;
      cnt_q <= '0;
      strobe_q <= 1'b0;
      sel_q <= 3'h0;
      pending_q <= 1'b0;
      fault_n_q <= 1'b1;
      oe_q <= PUSH_PULL;
      faults_q <= 32'h00000000;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      strobe_q <= strobe_d;
      sel_q <= sel_d;
      pending_q <= pending_d;
      fault_n_q <= fault_n_d;
      oe_q <= oe_d;
      faults_q <= faults_d;
    end
  end

  // Status word gathered for reads
  always_comb begin
    status_word = 32'h00000000;
    status_word[pswd_pkg::STAT_STATE_LSB +: 3] = state_q;
    status_word[pswd_pkg::STAT_FAULT_BIT] = !fault_n_q;
    status_word[pswd_pkg::STAT_STROBE_BIT] = strobe_q;
    status_word[pswd_pkg::STAT_PENDING_BIT] = pending_q;
    status_word[pswd_pkg::STAT_SEL_LSB +: 3] = sel_q;
  end

  // One wait state: read data is loaded as the request is first seen and
  // stands when waitrequest drops; a write lands on that second edge
  always_comb begin
    wreq_d = 1'b1;
    rdata_d = rdata_q;
    ctrl_d = ctrl_q;
    if ((avs_read_in || avs_write_in) && wreq_q) begin
      wreq_d = 1'b0;
      rdata_d = 32'h00000000;
      if (avs_read_in) begin
        if (avs_address_in == pswd_pkg::REG_CTRL) begin
          rdata_d = {24'h000000, ctrl_q};
        end else if (avs_address_in == pswd_pkg::REG_STATUS) begin
          rdata_d = status_word;
        end else if (avs_address_in == pswd_pkg::REG_COUNT) begin
          rdata_d = 32'(cnt_q);
        end else if (avs_address_in == pswd_pkg::REG_FAULTS) begin
          rdata_d = faults_q;
        end
      end
    end else if (avs_write_in && !wreq_q) begin
      // Only the low byte holds control bits
      if (avs_address_in == pswd_pkg::REG_CTRL && avs_byteenable_in[0]) begin
        ctrl_d = avs_writedata_in[7:0];
      end
    end
  end

  // Register slave flops
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      wreq_q <= 1'b1;
      rdata_q <= 32'h00000000;
      ctrl_q <= pswd_pkg::CTRL_RESET;
    end else begin
      wreq_q <= wreq_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
    end
  end

  // Outputs straight from flops
  assign fault_pulse_out = fault_n_q;
  assign fault_pulse_oe_out = oe_q;
  assign avs_readdata_out = rdata_q;
  assign avs_waitrequest_out = wreq_q;

endmodule // pswd_top

// ==== pswd_monitor.sv ====
// Checker on the pin side of pswd_top.
// Assumes one clock and the top's TICK_DIV.
`timescale 1ns/1ps
module pswd_monitor #(parameter int unsigned TICK_DIV = 20) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic strobe_input_in,
  input wire logic timing_select_bit0_in,
  input wire logic timing_select_bit1_in,
  input wire logic timing_select_bit2_in,
  input wire logic fault_pulse_out,
  input wire logic fault_pulse_oe_out
);
  logic f, s_q;
  logic [2:0] sel, sel_q;
  int qt_q, qt_d, lo_q, lo_d, st_q, st_d;
  assign f = fault_pulse_out;
  assign sel = {timing_select_bit2_in, timing_select_bit1_in, timing_select_bit0_in};
  // Quiet time restarts on any strobe edge and all through a pulse
  always_comb begin
    qt_d = (!f || s_q != strobe_input_in) ? 0 : qt_q + 1;
    lo_d = f ? 0 : lo_q + 1;
    st_d = (sel != sel_q) ? 0 : st_q + 1;
  end
  always_ff @(posedge ref_clk_in) begin
    s_q <= strobe_input_in;
    sel_q <= sel;
    qt_q <= rstn_in ? qt_d : 0;
    lo_q <= rstn_in ? lo_d : 0;
    st_q <= rstn_in ? st_d : 0;
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_fall;
    $fell(f);
  endsequence
  a_settle_quiet: assert property (st_q < 299 * TICK_DIV && f |=> f) else $error("settle");
  a_fall_after_settle: assert property (s_fall |-> st_q >= 299 * TICK_DIV) else $error("early");
  a_no_early_fault: assert property (s_fall |-> qt_q >= 29 * TICK_DIV) else $error("short");
  a_pulse_width: assert property ($rose(f) |-> lo_q >= 999 * TICK_DIV) else $error("pulse");
  a_release_clears: assert property ($rose(f) |-> f [*8]) else $error("refault");
  a_off_stays_high: assert property (sel == 3'h3 && $stable(sel) && f |=> f) else $error("off");
  a_oe_when_low: assert property (!f |-> fault_pulse_oe_out) else $error("undriven");
  a_reset_high: assert property ($rose(rstn_in) |-> f) else $error("reset");
endmodule // pswd_monitor
bind pswd_top pswd_monitor #(.TICK_DIV(TICK_DIV)) u_mon (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
  .strobe_input_in(strobe_input_in), .timing_select_bit0_in(timing_select_bit0_in),
  .timing_select_bit1_in(timing_select_bit1_in), .timing_select_bit2_in(timing_select_bit2_in),
  .fault_pulse_out(fault_pulse_out), .fault_pulse_oe_out(fault_pulse_oe_out));

// ==== pswd_proc_model.sv ====
// Processor stand-in that toggles the strobe.
// Assumes gap_in counts clock cycles.
`timescale 1ns/1ps
module pswd_proc_model (
  input wire logic clk_in,
  input wire logic en_in,
  input wire logic [7:0] gap_in,
  output logic strobe_out = 1'b0
);
  logic [7:0] n_q = 8'h00;
  // Level holds when stopped, as a hung program would leave it
  always @(posedge clk_in) begin
    n_q <= (n_q >= gap_in) ? 8'h00 : n_q + 8'h01;
    if (en_in && n_q >= gap_in)
      strobe_out <= ~strobe_out;
  end
endmodule // pswd_proc_model

// ==== pswd_top_tb.sv ====
// Bench for pswd_top: third variant, push-pull, two-cycle tick.
// Assumes pswd_proc_model and the bound checker.
`timescale 1ns/1ps
module pswd_top_tb;
  logic clk = 1'b0, rstn = 1'b0, en = 1'b0, rd = 1'b0, wr = 1'b0, stb, flt, wq;
  logic [31:0] wdat = 32'h00000000;
  logic [2:0] sel = 3'h4;
  logic [3:0] adr = 4'h0;
  logic [7:0] gap = 8'h08;
  logic [31:0] rdat;
  int seed = 32'h1D3A;
  int miscompares = 0, checks = 0, cyc = 0, lows = 0;
  initial forever #25 clk = ~clk;
  pswd_proc_model proc (.clk_in(clk), .en_in(en), .gap_in(gap), .strobe_out(stb));
  pswd_top #(.VARIANT(5), .TICK_DIV(2)) dut (.ref_clk_in(clk), .rstn_in(rstn), .strobe_input_in(stb),
    .timing_select_bit0_in(sel[0]), .timing_select_bit1_in(sel[1]), .timing_select_bit2_in(sel[2]),
    .fault_pulse_out(flt), .fault_pulse_oe_out(), .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdat), .avs_byteenable_in(4'hF), .avs_readdata_out(rdat), .avs_waitrequest_out(wq));
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc > 40000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s exp %0h got %0h", nm, exp, got);
    end
  endtask
  task automatic watch(input int n);
    lows = 0;
    repeat (n) begin
      @(posedge clk);
      lows += int'(flt === 1'b0);
    end
  endtask
  // Request held until waitrequest is seen low
  task automatic xfer(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    rd <= !w;
    wr <= w;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wq !== 1'b0 && n < 50);
    rd <= 1'b0;
    wr <= 1'b0;
    chk("answer", n < 50, 1);
  endtask
  task automatic end_sim();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    xfer(pswd_pkg::REG_CTRL, 1'b0, 32'h00000000);
    chk("ctrl", rdat[7:0], pswd_pkg::CTRL_RESET);
    xfer(4'h2, 1'b0, 32'h00000000);
    chk("unmapped", rdat, 32'h00000000);
    xfer(pswd_pkg::REG_CTRL, 1'b1, 32'h00000050);
    xfer(pswd_pkg::REG_CTRL, 1'b0, 32'h00000000);
    chk("ctrl back", rdat[7:0], 8'h50);
    en <= 1'b1;
    // Random gaps, all inside the 30 us timeout
    repeat (8) begin
      gap <= 8'h04 + 8'($random(seed) & 32'h1F);
      watch(300);
      chk("toggling", lows, 0);
    end
    en <= 1'b0;
    watch(200);
    chk("stuck", lows != 0, 1);
    watch(1800);
    chk("pulse", lows, 1800);
    rstn <= 1'b0;
    sel <= 3'h3;
    watch(2);
    rstn <= 1'b1;
    watch(3000);
    chk("off", lows, 0);
    sel <= 3'h5;
    watch(3000);
    chk("first edge", lows, 0);
    sel <= 3'h0;
    watch(6500);
    chk("startup", lows, 0);
    watch(6500);
    chk("timeout", lows != 0, 1);
    end_sim();
  end
endmodule // pswd_top_tb
